/* periph_pkg.sv */
package periph_pkg;
	// Colour select codes
	localparam logic [1:0] LED_NONE = 2'h0;
	localparam logic [1:0] LED_RED = 2'h1;
	localparam logic [1:0] LED_GREEN = 2'h2;
	localparam logic [1:0] LED_BLUE = 2'h3;
	// Colour slot length of the display sequence, in clocks
	localparam logic [15:0] SLOT_CYCLES = 16'h0100;
	// Auto-initialization length, in clocks
	localparam logic [15:0] INIT_CYCLES = 16'h0040;
	// Flash clock half period, in clocks
	localparam logic [3:0] SCLK_HALF = 4'h2;
	// Conversion result width
	localparam int ADC_BITS = 8;
	// Settle time per trial bit, in clocks
	localparam logic [7:0] SAR_SETTLE = 8'h10;
	// Control target address on the control bus
	localparam logic [6:0] TARGET_ADDR = 7'h1B;
	// Boot sequence states, Gray coded
	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_INIT = 2'b01,
		ST_RUN = 2'b11
	} boot_state_t;
endpackage : periph_pkg

/* sar_if.sv */
`timescale 1ns/1ps
// Link between the top and the conversion engine
interface sar_if;
	logic start; // Begin a conversion
	logic cmp; // Synchronised comparator result
	logic charge; // Ramp charge drive
	logic done; // Conversion finished pulse
	logic [7:0] result; // Last result
	modport engine (input start, input cmp, output charge, output done, output result);
	modport ctrl (output start, output cmp, input charge, input done, input result);
endinterface : sar_if

/* sar_adc.sv */
`timescale 1ns/1ps
// Successive-approximation engine: trial code set as charge duty target
module sar_adc (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	sar_if.engine sif
);
	import periph_pkg::*;
	logic [ADC_BITS-1:0] code_r, code_nxt; // Trial code
	logic [ADC_BITS-1:0] res_r, res_nxt; // Held result
	logic [3:0] bit_r, bit_nxt; // Bit under trial
	logic [7:0] set_r, set_nxt; // Settle counter
	logic busy_r, busy_nxt; // Conversion running
	logic done_r, done_nxt; // Finish pulse
	logic [ADC_BITS-1:0] ramp_r, ramp_nxt; // Ramp counter for charge duty
	logic chg_r, chg_nxt; // Charge output

	// Next-state of the conversion
	always_comb begin
		code_nxt = code_r;
		res_nxt = res_r;
		bit_nxt = bit_r;
		set_nxt = set_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		ramp_nxt = ramp_r + 1'b1;
		chg_nxt = busy_r && (ramp_r < code_r); // Charge duty follows trial code
		if (!busy_r) begin
			if (sif.start) begin
				busy_nxt = 1'b1;
				bit_nxt = 4'(ADC_BITS - 1);
				code_nxt = '0;
				code_nxt[ADC_BITS-1] = 1'b1;
				set_nxt = '0;
			end
		end else if (set_r != SAR_SETTLE) begin
			set_nxt = set_r + 8'h01;
		end else begin
			// Comparator high: ramp above thermistor, drop the bit
			if (sif.cmp) begin
				code_nxt[bit_r[2:0]] = 1'b0;
			end
			set_nxt = '0;
			if (bit_r == 4'h0) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
				res_nxt = sif.cmp ? {code_r[ADC_BITS-1:1], 1'b0} : code_r;
			end else begin
				bit_nxt = bit_r - 4'h1;
				code_nxt[bit_r[2:0] - 3'h1] = 1'b1;
			end
		end
	end

	// Register stage
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			code_r <= '0;
			res_r <= '0;
			bit_r <= '0;
			set_r <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			ramp_r <= '0;
			chg_r <= 1'b0;
		end else begin
			code_r <= code_nxt;
			res_r <= res_nxt;
			bit_r <= bit_nxt;
			set_r <= set_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
			ramp_r <= ramp_nxt;
			chg_r <= chg_nxt;
		end
	end

	assign sif.charge = chg_r;
	assign sif.done = done_r;
	assign sif.result = res_r;
endmodule : sar_adc

/* periph_ctrl.sv */
`timescale 1ns/1ps
// Functional notes
// - Sequence drives colour select 01/10/11.
// - Colour select low while chip reset.
// - Colour select low during auto-initialization.
// - Host interrupt undriven while in reset.
// - Ramp charge plus comparator successive approximation.
// - Control bus port acts as target.
// - Device generates the flash serial clock.
module periph_ctrl (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic chip_reset_low_i, // Chip reset pin, active low
	input wire logic comparator_result_in_i, // External comparator
	input wire logic control_bus_clock_pin_i, // Bus clock level
	input wire logic control_bus_data_pin_i, // Bus data level
	output logic control_bus_data_pin_o, // Always low when driven
	output logic control_bus_data_pin_oe_o, // Pull data low
	output logic [1:0] led_color_select_o, // Colour enable code
	output logic host_irq_o, // Interrupt level
	output logic host_irq_oe_o, // Interrupt driven
	output logic ramp_charge_out_o, // Comparator charge drive
	output logic flash_serial_clock_o, // Flash clock
	output logic [7:0] temp_result_o, // Last conversion result
	output logic [7:0] ctrl_cmd_o, // Last command byte received
	output logic ctrl_cmd_valid_o // Command byte pulse
);
	import periph_pkg::*;

	// Pin synchronisers, two stages each
	logic [3:0] s1_r, s2_r;
	always_ff @(posedge mclk_i) begin
		s1_r <= {chip_reset_low_i, comparator_result_in_i,
			control_bus_clock_pin_i, control_bus_data_pin_i};
		s2_r <= s1_r;
	end
	logic rst_n_s, cmp_s, scl_s, sda_s;
	assign {rst_n_s, cmp_s, scl_s, sda_s} = s2_r;
	logic hold; // Any reset in force
	assign hold = sys_rst_i | ~rst_n_s;

	// Boot sequence and colour sequencer state
	boot_state_t st_r, st_nxt;
	logic [15:0] cnt_r, cnt_nxt; // Init and slot timer
	logic [1:0] led_r, led_nxt; // Colour select
	logic irq_r, irq_nxt; // Interrupt level
	logic irq_oe_r, irq_oe_nxt; // Interrupt enable

	// Next values of boot and sequencer
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		led_nxt = led_r;
		irq_nxt = irq_r;
		irq_oe_nxt = 1'b1;
		case (st_r)
			ST_RESET: begin
				led_nxt = LED_NONE;
				irq_oe_nxt = 1'b0;
				st_nxt = ST_INIT;
				cnt_nxt = '0;
			end
			ST_INIT: begin
				led_nxt = LED_NONE;
				irq_nxt = 1'b1; // High while initializing
				cnt_nxt = cnt_r + 16'h0001;
				if (cnt_r == INIT_CYCLES - 16'h0001) begin
					st_nxt = ST_RUN;
					irq_nxt = 1'b0; // Falling edge marks completion
					cnt_nxt = '0;
					led_nxt = LED_RED;
				end
			end
			ST_RUN: begin
				irq_nxt = 1'b0;
				cnt_nxt = cnt_r + 16'h0001;
				// Step red, green, blue per slot
				if (cnt_r == SLOT_CYCLES - 16'h0001) begin
					cnt_nxt = '0;
					case (led_r)
						LED_RED: led_nxt = LED_GREEN;
						LED_GREEN: led_nxt = LED_BLUE;
						default: led_nxt = LED_RED;
					endcase
				end
			end
			default: st_nxt = ST_RESET;
		endcase
		if (hold) begin
			st_nxt = ST_RESET;
			led_nxt = LED_NONE;
			irq_oe_nxt = 1'b0;
			irq_nxt = 1'b0;
			cnt_nxt = '0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			st_r <= ST_RESET;
			cnt_r <= '0;
			led_r <= LED_NONE;
			irq_r <= 1'b0;
			irq_oe_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			led_r <= led_nxt;
			irq_r <= irq_nxt;
			irq_oe_r <= irq_oe_nxt;
		end
	end
	logic running;
	assign running = (st_r == ST_RUN);

	// Flash clock divider, idles low
	logic [3:0] div_r, div_nxt;
	logic sclk_r, sclk_nxt;
	always_comb begin
		div_nxt = div_r + 4'h1;
		sclk_nxt = sclk_r;
		if (div_r == SCLK_HALF - 4'h1) begin
			div_nxt = '0;
			sclk_nxt = ~sclk_r;
		end
		if (hold) begin
			div_nxt = '0;
			sclk_nxt = 1'b0;
		end
	end
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			div_r <= '0;
			sclk_r <= 1'b0;
		end else begin
			div_r <= div_nxt;
			sclk_r <= sclk_nxt;
		end
	end

	// Temperature conversion engine
	sar_if sif ();
	logic start_r, start_nxt;
	assign start_nxt = running & ~start_r; // Restart after each result
	assign sif.start = start_r;
	assign sif.cmp = cmp_s;
	sar_adc u_sar (
		.mclk_i(mclk_i),
		.sys_rst_i(hold),
		.sif(sif)
	);
	logic chg_r;
	logic [7:0] res_r;
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			start_r <= 1'b0;
			chg_r <= 1'b0;
			res_r <= '0;
		end else begin
			start_r <= start_nxt & ~(running & ~sif.done & start_r);
			chg_r <= sif.charge;
			res_r <= sif.done ? sif.result : res_r;
		end
	end

	// Control bus target: address match then write bytes
	logic scl_d_r, sda_d_r;
	logic [3:0] bc_r, bc_nxt; // Bit count in byte
	logic [7:0] sh_r, sh_nxt; // Shift register
	logic act_r, act_nxt; // Transfer addressed to us
	logic adr_r, adr_nxt; // Expecting address byte
	logic ack_r, ack_nxt; // Pulling data low
	logic [7:0] cmd_r, cmd_nxt;
	logic cv_r, cv_nxt;
	always_comb begin
		bc_nxt = bc_r;
		sh_nxt = sh_r;
		act_nxt = act_r;
		adr_nxt = adr_r;
		ack_nxt = ack_r;
		cmd_nxt = cmd_r;
		cv_nxt = 1'b0;
		if (scl_s && sda_d_r && !sda_s) begin
			// Start condition
			bc_nxt = '0;
			adr_nxt = 1'b1;
			act_nxt = 1'b0;
			ack_nxt = 1'b0;
		end else if (scl_s && !sda_d_r && sda_s) begin
			// Stop condition
			adr_nxt = 1'b0;
			act_nxt = 1'b0;
			ack_nxt = 1'b0;
		end else if (scl_s && !scl_d_r) begin
			// Rising clock: sample data
			if (bc_r != 4'h8) begin
				sh_nxt = {sh_r[6:0], sda_s};
				bc_nxt = bc_r + 4'h1;
			end else begin
				bc_nxt = '0;
			end
		end else if (!scl_s && scl_d_r) begin
			// Falling clock: drive or release acknowledge
			ack_nxt = 1'b0;
			if (bc_r == 4'h8) begin
				if (adr_r) begin
					// Answer only when out of initialization
					act_nxt = running && (sh_r[7:1] == TARGET_ADDR) && !sh_r[0];
					ack_nxt = act_nxt;
					adr_nxt = 1'b0;
				end else if (act_r) begin
					cmd_nxt = sh_r;
					cv_nxt = 1'b1;
					ack_nxt = 1'b1;
				end
			end
		end
		if (hold) begin
			act_nxt = 1'b0;
			adr_nxt = 1'b0;
			ack_nxt = 1'b0;
			bc_nxt = '0;
		end
	end
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			bc_r <= '0;
			sh_r <= '0;
			act_r <= 1'b0;
			adr_r <= 1'b0;
			ack_r <= 1'b0;
			cmd_r <= '0;
			cv_r <= 1'b0;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
			bc_r <= bc_nxt;
			sh_r <= sh_nxt;
			act_r <= act_nxt;
			adr_r <= adr_nxt;
			ack_r <= ack_nxt;
			cmd_r <= cmd_nxt;
			cv_r <= cv_nxt;
		end
	end

	// Outputs straight from flip-flops, data level a constant low
	assign control_bus_data_pin_o = 1'b0;
	assign control_bus_data_pin_oe_o = ack_r;
	assign led_color_select_o = led_r;
	assign host_irq_o = irq_r;
	assign host_irq_oe_o = irq_oe_r;
	assign ramp_charge_out_o = chg_r;
	assign flash_serial_clock_o = sclk_r;
	assign temp_result_o = res_r;
	assign ctrl_cmd_o = cmd_r;
	assign ctrl_cmd_valid_o = cv_r;
endmodule : periph_ctrl

/* periph_asserts.sv */
`timescale 1ns/1ps
// Port-level checker for the peripheral control block
module periph_asserts
	import periph_pkg::*;
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic chip_reset_low_i,
	input wire logic control_bus_data_pin_o,
	input wire logic control_bus_data_pin_oe_o,
	input wire logic [1:0] led_color_select_o,
	input wire logic host_irq_o,
	input wire logic host_irq_oe_o,
	input wire logic flash_serial_clock_o
);
	import periph_pkg::*;
	logic [1:0] led_q_r; // Colour one cycle back
	logic [8:0] stay_r; // Cycles the colour has stood
	logic [8:0] stay_nxt;
	// Count unchanged cycles, restart on any change
	always_comb begin
		stay_nxt = (led_color_select_o == led_q_r) ? stay_r + 9'h001 : 9'h000;
	end
	// Register the helper state
	always_ff @(posedge mclk_i) begin
		led_q_r <= led_color_select_o;
		stay_r <= stay_nxt;
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	led_rst_zero_a: assert property ($fell(sys_rst_i) |->
		led_color_select_o == LED_NONE)
		else $error("led lit after reset");
	irq_rst_float_a: assert property ($fell(sys_rst_i) |-> !host_irq_oe_o)
		else $error("irq driven after reset");
	irq_chip_float_a: assert property (!chip_reset_low_i [*5] |->
		!host_irq_oe_o && led_color_select_o == LED_NONE)
		else $error("outputs active in chip reset");
	led_init_off_a: assert property (host_irq_oe_o && host_irq_o |->
		led_color_select_o == LED_NONE)
		else $error("led lit during init");
	// Interrupt is driven high one cycle after init entry, so it stands 63 cycles
	init_length_a: assert property ($rose(host_irq_oe_o) |-> ##63 $fell(host_irq_o))
		else $error("init length wrong");
	led_run_red_a: assert property ($fell(host_irq_o) |->
		##[0:1] led_color_select_o == LED_RED)
		else $error("run did not start red");
	led_order_a: assert property ($changed(led_color_select_o) &&
		$past(led_color_select_o) != LED_NONE && led_color_select_o != LED_NONE |->
		led_color_select_o == ($past(led_color_select_o) == LED_BLUE ? LED_RED :
		$past(led_color_select_o) + 2'h1))
		else $error("colour order wrong");
	slot_len_a: assert property ($changed(led_color_select_o) &&
		$past(led_color_select_o) != LED_NONE && led_color_select_o != LED_NONE |->
		stay_r == 9'h0FF)
		else $error("slot length wrong");
	ack_run_only_a: assert property ($rose(control_bus_data_pin_oe_o) |->
		!(host_irq_oe_o && host_irq_o))
		else $error("ack during init");
	data_low_only_a: assert property (control_bus_data_pin_oe_o |->
		!control_bus_data_pin_o)
		else $error("data driven high");
	// Chip reset reaching the divider may cut a high phase short
	sclk_half_a: assert property ($past(chip_reset_low_i, 2) &&
		$rose(flash_serial_clock_o) |=> flash_serial_clock_o ##1 !flash_serial_clock_o)
		else $error("flash clock half period wrong");
endmodule : periph_asserts
bind periph_ctrl periph_asserts CHK (
	.mclk_i(mclk_i),
	.sys_rst_i(sys_rst_i),
	.chip_reset_low_i(chip_reset_low_i),
	.control_bus_data_pin_o(control_bus_data_pin_o),
	.control_bus_data_pin_oe_o(control_bus_data_pin_oe_o),
	.led_color_select_o(led_color_select_o),
	.host_irq_o(host_irq_o),
	.host_irq_oe_o(host_irq_oe_o),
	.flash_serial_clock_o(flash_serial_clock_o)
);

/* host_model.sv */
`timescale 1ns/1ps
// Host on the open-drain control bus and the pulled-up interrupt line
module host_model (
	input wire logic mclk_i,
	input wire logic dev_sda_oe_i,
	input wire logic irq_i,
	input wire logic irq_oe_i,
	output logic scl_o,
	output logic sda_o,
	output logic irq_line_o
);
	logic sda_low = 1'b0; // Host pulls data low
	initial scl_o = 1'b1;
	// Pull-ups win when nobody pulls low
	assign sda_o = !(sda_low || dev_sda_oe_i);
	assign irq_line_o = irq_oe_i ? irq_i : 1'b1;
	// One bus phase, above the four-cycle minimum
	task automatic ph;
		repeat (6) @(negedge mclk_i);
	endtask : ph
	// Byte out MSB first, then read the ack slot
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_low = !b[i];
			ph();
			scl_o = 1'b1;
			ph();
			scl_o = 1'b0;
		end
		sda_low = 1'b0;
		ph();
		scl_o = 1'b1;
		ph();
		ack = !sda_o;
		scl_o = 1'b0;
	endtask : put_byte
	// Start, address with write, one data byte, stop
	task automatic send(input logic [6:0] a, input logic [7:0] d, output logic ok);
		logic a1;
		logic a2;
		sda_low = 1'b1;
		ph();
		scl_o = 1'b0;
		put_byte({a, 1'b0}, a1);
		put_byte(d, a2);
		sda_low = 1'b1;
		ph();
		scl_o = 1'b1;
		ph();
		sda_low = 1'b0;
		ph();
		ok = a1 && a2;
	endtask : send
endmodule : host_model

/* tb_top.sv */
`timescale 1ns/1ps
// Self-checking bench for the peripheral control block
module tb_top;
	import periph_pkg::*;
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic chip_reset_low_i = 1'b1;
	logic comparator_result_in_i = 1'b0;
	logic control_bus_clock_pin_i, control_bus_data_pin_i, control_bus_data_pin_o;
	logic control_bus_data_pin_oe_o, host_irq_o, host_irq_oe_o, irq_line;
	logic ramp_charge_out_o, flash_serial_clock_o, ctrl_cmd_valid_o;
	logic [1:0] led_color_select_o;
	logic [7:0] temp_result_o, ctrl_cmd_o;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	int n_valid = 0; // Command strobes seen
	int n_charge = 0; // Cycles with charge drive high
	always #4 mclk_i = ~mclk_i;
	periph_ctrl DUT (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.chip_reset_low_i(chip_reset_low_i),
		.comparator_result_in_i(comparator_result_in_i),
		.control_bus_clock_pin_i(control_bus_clock_pin_i),
		.control_bus_data_pin_i(control_bus_data_pin_i),
		.control_bus_data_pin_o(control_bus_data_pin_o),
		.control_bus_data_pin_oe_o(control_bus_data_pin_oe_o),
		.led_color_select_o(led_color_select_o),
		.host_irq_o(host_irq_o),
		.host_irq_oe_o(host_irq_oe_o),
		.ramp_charge_out_o(ramp_charge_out_o),
		.flash_serial_clock_o(flash_serial_clock_o),
		.temp_result_o(temp_result_o),
		.ctrl_cmd_o(ctrl_cmd_o),
		.ctrl_cmd_valid_o(ctrl_cmd_valid_o)
	);
	// Tally strobes and charge cycles away from the launching edge
	always @(negedge mclk_i) begin
		if (ctrl_cmd_valid_o === 1'b1) n_valid++;
		if (ramp_charge_out_o === 1'b1) n_charge++;
	end
	host_model HOST (.mclk_i(mclk_i), .dev_sda_oe_i(control_bus_data_pin_oe_o),
		.irq_i(host_irq_o), .irq_oe_i(host_irq_oe_o), .scl_o(control_bus_clock_pin_i),
		.sda_o(control_bus_data_pin_i), .irq_line_o(irq_line));
	// Count and report one comparison
	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask : chk
	// Print counts and verdict, then stop
	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : test_done
	// Wait for the interrupt to drop, led dark meanwhile
	task automatic wait_init(output int n);
		n = 0;
		do begin
			@(negedge mclk_i);
			n++;
			if (irq_line) chk(led_color_select_o === LED_NONE, "led in init");
		end while (irq_line !== 1'b0 && n < 200);
	endtask : wait_init
	task automatic t_boot;
		int n;
		repeat (3) @(negedge mclk_i);
		chk(led_color_select_o === LED_NONE, "led in reset");
		chk(irq_line === 1'b1 && host_irq_oe_o === 1'b0, "irq in reset");
		sys_rst_i = 1'b0;
		wait_init(n);
		chk(n >= 64 && n <= 67, "init length");
		$display("boot test done");
	endtask : t_boot
	task automatic t_led;
		logic [1:0] exp;
		exp = LED_RED;
		repeat (128) @(negedge mclk_i);
		for (int i = 0; i < 4; i++) begin
			chk(led_color_select_o === exp, "led colour");
			exp = (exp == LED_BLUE) ? LED_RED : exp + 2'h1;
			repeat (256) @(negedge mclk_i);
		end
		$display("led test done");
	endtask : t_led
	task automatic t_ctrl;
		logic ok;
		int v;
		chk(irq_line === 1'b0, "init still running");
		v = n_valid;
		HOST.send(TARGET_ADDR, 8'hA5, ok);
		chk(ok === 1'b1 && ctrl_cmd_o === 8'hA5 && n_valid == v + 1, "command taken");
		HOST.send(TARGET_ADDR + 7'h01, 8'h3C, ok);
		chk(ok === 1'b0 && ctrl_cmd_o === 8'hA5 && n_valid == v + 1, "foreign address");
		$display("control test done");
	endtask : t_ctrl
	task automatic t_sar;
		int c;
		comparator_result_in_i = 1'b1;
		c = n_charge;
		repeat (400) @(negedge mclk_i);
		chk(temp_result_o === 8'h00, "ramp always above");
		chk(n_charge > c, "no charge drive");
		comparator_result_in_i = 1'b0;
		c = n_charge;
		repeat (400) @(negedge mclk_i);
		chk(temp_result_o === 8'hFF, "ramp always below");
		chk(n_charge > c, "no charge drive");
		$display("conversion test done");
	endtask : t_sar
	task automatic t_chip;
		int n;
		chip_reset_low_i = 1'b0;
		repeat (8) @(negedge mclk_i);
		chk(led_color_select_o === LED_NONE, "led in chip reset");
		chk(irq_line === 1'b1 && host_irq_oe_o === 1'b0, "irq in chip reset");
		chip_reset_low_i = 1'b1;
		wait_init(n);
		chk(irq_line === 1'b0 && n >= 64 && n <= 70, "init again");
		chk(led_color_select_o === LED_RED, "red after init");
		$display("chip reset test done");
	endtask : t_chip
	// Cut a hang short
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 10000) begin
			n_errors++;
			test_done();
		end
	end
	initial begin
		@(negedge mclk_i);
		t_boot();
		t_led();
		t_ctrl();
		t_sar();
		t_chip();
		test_done();
	end
endmodule : tb_top
